// *** verilog/citc_pkg.sv ***
// constants and types for the dead-time compensation block
// assumes a single 40 MHz clock domain
package citc_pkg;
	localparam int CLK_HZ = 40000000;
	// ********************
	// timing
	// ********************
	localparam int SAMPLE_PERIOD_US = 1000;
	localparam int SAMPLE_PERIOD_CYCLES = (CLK_HZ / 1000000) * SAMPLE_PERIOD_US;
	localparam int CTRL_CYCLE_NS = 25000;
	localparam int CTRL_CYCLE_CYCLES = CTRL_CYCLE_NS / 25;
	localparam int SWITCH_DELAY_CYCLES = CTRL_CYCLE_CYCLES / 2;
	// ********************
	// error classes
	// ********************
	localparam logic [6:0] ERR_NONE = 7'h00;
	localparam logic [6:0] ERR_FATAL_MAX = 7'h13;
	localparam logic [6:0] ERR_WARN_MIN = 7'h14;
	localparam logic [6:0] ERR_WARN_MAX = 7'h63;
	localparam int FLASH_HALF_CYCLES = 2000000;
	typedef enum logic [1:0] {
		CITC_PATH,
		CITC_TIMED,
		CITC_DIRECT
	} citc_method_t;
	localparam citc_method_t METHOD_RESET = CITC_PATH;
endpackage

// *** verilog/citc_sync.sv ***
// two-stage synchroniser for pin inputs
// assumes the input is asynchronous to clk
module citc_sync import citc_pkg::*; #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// *** verilog/citc_error.sv ***
// error holding, classing and diagnosis flashing
// assumes error reports are single-cycle pulses from the same clock
module citc_error import citc_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic err_valid,
	input wire logic [6:0] err_code,
	input wire logic ack,
	output logic [6:0] err_code_out,
	output logic err_pending,
	output logic err_fatal,
	output logic diag_led
);
	logic [21:0] flash_cnt_reg;
	logic fatal_reg;
	assign err_fatal = fatal_reg;
	// fatal codes are never acknowledged away
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_code_out <= ERR_NONE;
			err_pending <= 1'b0;
		end else if (err_valid && err_code != ERR_NONE) begin
			err_code_out <= err_code;
			err_pending <= 1'b1;
		end else if (ack && !fatal_reg) begin
			err_code_out <= ERR_NONE;
			err_pending <= 1'b0;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fatal_reg <= 1'b0;
		end else if (err_valid && err_code != ERR_NONE && err_code <= ERR_FATAL_MAX) begin
			fatal_reg <= 1'b1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_cnt_reg <= '0;
			diag_led <= 1'b0;
		end else if (!err_pending) begin
			flash_cnt_reg <= '0;
			diag_led <= 1'b0;
		end else if (flash_cnt_reg == 22'(FLASH_HALF_CYCLES - 1)) begin
			flash_cnt_reg <= '0;
			diag_led <= !diag_led;
		end else begin
			flash_cnt_reg <= flash_cnt_reg + 22'h1;
		end
	end
endmodule

// *** verilog/citc_top.sv ***
// dead-time compensation core of an electronic cam controller
// assumes position from an encoder pin bus and cam windows from configuration
// ********************
// main module
// ********************
// What this block does
// - required correction is recomputed each control cycle from current speed, any method
// - correction counts increments; compensated outputs switch that many increments early
// - path mode steps applied correction at most one increment per position change
// - path mode holds correction while position is still
// - timed mode steps correction at most one increment each control cycle
// - direct mode loads required correction every cycle without limit
// - three selectable methods, path-dependent after reset
// - recalc period in ms equals highest compensated output index
// - encoder-to-output delay constant, half a control cycle
// - speed sampled every recalc period and averaged per ms, setting correction resolution
// - error codes 1..19 are fatal and stop operation for good
// - any error shows its code and flashes the diagnosis indicator fast
// - warnings 20..99 keep outputs updating at normal rate
module citc_top import citc_pkg::*; #(
	parameter int N_OUT = 16,
	parameter int PW = 16,
	parameter int CW = 12,
	parameter int SAMPLE_CYCLES = SAMPLE_PERIOD_CYCLES,
	parameter int CTRL_CYCLES = CTRL_CYCLE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [PW-1:0] enc_pos,
	input wire logic [1:0] method_sel,
	input wire logic [9:0] deadtime_ms,
	input wire logic [N_OUT-1:0] comp_enable,
	input wire logic [N_OUT*PW-1:0] cam_on,
	input wire logic [N_OUT*PW-1:0] cam_off,
	input wire logic err_valid,
	input wire logic [6:0] err_code,
	input wire logic err_ack,
	output logic [N_OUT-1:0] cam_out,
	output logic [CW-1:0] deadtime_correction,
	output logic [CW-1:0] required_correction,
	output logic [4:0] recalc_period_ms,
	output logic [6:0] err_code_out,
	output logic err_pending,
	output logic err_fatal,
	output logic diag_led,
	output logic cycle_tick
);
	logic [PW-1:0] pos_sync;
	logic [PW-1:0] pos_reg;
	logic [PW-1:0] pos_prev_reg;
	logic [PW-1:0] speed_last_pos_reg;
	logic [PW-1:0] speed_reg;
	logic [PW-1:0] delta;
	logic [31:0] ctrl_cnt_reg;
	logic [31:0] sample_cnt_reg;
	logic [4:0] ms_cnt_reg;
	logic [4:0] hi_idx;
	logic recalc_tick;
	logic sample_tick;
	logic pos_moved;
	logic [CW-1:0] req_reg;
	logic [CW-1:0] act_reg;
	logic [CW-1:0] act_next;
	citc_method_t method_reg;
	logic [PW-1:0] out_pos_reg;
	logic [31:0] out_delay_cnt_reg;
	logic out_pending_reg;
	logic [N_OUT-1:0] cam_next;
	logic [PW+10-1:0] prod;

	citc_sync #(.W(PW)) u_sync (
		.clk(clk),
		.rst(rst),
		.d(enc_pos),
		.q(pos_sync)
	);

	citc_error u_err (
		.clk(clk),
		.rst(rst),
		.err_valid(err_valid),
		.err_code(err_code),
		.ack(err_ack),
		.err_code_out(err_code_out),
		.err_pending(err_pending),
		.err_fatal(err_fatal),
		.diag_led(diag_led)
	);

	// ********************
	// control cycle and sample timers
	// ********************
	assign cycle_tick = (ctrl_cnt_reg == 32'(CTRL_CYCLES - 1));
	assign sample_tick = (sample_cnt_reg == 32'(SAMPLE_CYCLES - 1));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_cnt_reg <= '0;
		end else if (cycle_tick) begin
			ctrl_cnt_reg <= '0;
		end else begin
			ctrl_cnt_reg <= ctrl_cnt_reg + 32'h1;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sample_cnt_reg <= '0;
		end else if (sample_tick) begin
			sample_cnt_reg <= '0;
		end else begin
			sample_cnt_reg <= sample_cnt_reg + 32'h1;
		end
	end

	// highest compensated output, one-based, sets recalc period in ms
	always_comb begin
		hi_idx = 5'h00;
		for (int i = 0; i < N_OUT; i++) begin
			if (comp_enable[i]) begin
				hi_idx = 5'(i + 1);
			end
		end
	end
	assign recalc_period_ms = hi_idx;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ms_cnt_reg <= '0;
		end else if (sample_tick) begin
			if (ms_cnt_reg + 5'h1 >= hi_idx) begin
				ms_cnt_reg <= '0;
			end else begin
				ms_cnt_reg <= ms_cnt_reg + 5'h1;
			end
		end
	end
	assign recalc_tick = sample_tick && (ms_cnt_reg + 5'h1 >= hi_idx);

	// ********************
	// position and speed
	// ********************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos_reg <= '0;
			pos_prev_reg <= '0;
		end else if (cycle_tick) begin
			pos_reg <= pos_sync;
			pos_prev_reg <= pos_reg;
		end
	end
	assign pos_moved = (pos_reg != pos_prev_reg);
	assign delta = pos_sync - speed_last_pos_reg;
	// speed held as increments per sample period, magnitude of the signed distance
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			speed_last_pos_reg <= '0;
			speed_reg <= '0;
		end else if (recalc_tick) begin
			speed_last_pos_reg <= pos_sync;
			speed_reg <= (delta[PW-1] ? PW'(-delta) : delta) / PW'(hi_idx == 5'h00 ? 5'h01 : hi_idx);
		end
	end

	// required correction: increments per ms times dead time in ms
	assign prod = speed_reg * deadtime_ms;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_reg <= '0;
		end else if (cycle_tick) begin
			req_reg <= (prod > (PW+10)'({CW{1'b1}})) ? {CW{1'b1}} : prod[CW-1:0];
		end
	end
	assign required_correction = req_reg;

	// ********************
	// method and applied correction
	// ********************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			method_reg <= METHOD_RESET;
		end else if (cycle_tick) begin
			unique case (method_sel)
				2'h1: method_reg <= CITC_TIMED;
				2'h2: method_reg <= CITC_DIRECT;
				default: method_reg <= CITC_PATH;
			endcase
		end
	end
	always_comb begin
		act_next = act_reg;
		unique case (method_reg)
			CITC_PATH: begin
				if (pos_moved && act_reg < req_reg) begin
					act_next = act_reg + CW'(1);
				end else if (pos_moved && act_reg > req_reg) begin
					act_next = act_reg - CW'(1);
				end
			end
			CITC_TIMED: begin
				if (act_reg < req_reg) begin
					act_next = act_reg + CW'(1);
				end else if (act_reg > req_reg) begin
					act_next = act_reg - CW'(1);
				end
			end
			CITC_DIRECT: act_next = req_reg;
			default: act_next = act_reg;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			act_reg <= '0;
		end else if (cycle_tick && !err_fatal) begin
			act_reg <= act_next;
		end
	end
	assign deadtime_correction = act_reg;

	// ********************
	// cam evaluation
	// ********************
	// delayed launch keeps read-to-output latency fixed regardless of load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_pos_reg <= '0;
			out_delay_cnt_reg <= '0;
			out_pending_reg <= 1'b0;
		end else if (cycle_tick) begin
			out_pos_reg <= pos_sync;
			out_delay_cnt_reg <= '0;
			out_pending_reg <= 1'b1;
		end else if (out_pending_reg) begin
			out_delay_cnt_reg <= out_delay_cnt_reg + 32'h1;
			if (out_delay_cnt_reg == 32'(CTRL_CYCLES / 2 - 1)) begin
				out_pending_reg <= 1'b0;
			end
		end
	end
	genvar g;
	generate
		for (g = 0; g < N_OUT; g++) begin : g_cam
			logic [PW-1:0] eff;
			logic [PW-1:0] on_p;
			logic [PW-1:0] off_p;
			assign on_p = cam_on[g*PW +: PW];
			assign off_p = cam_off[g*PW +: PW];
			assign eff = comp_enable[g] ? out_pos_reg + PW'(act_reg) : out_pos_reg;
			assign cam_next[g] = (on_p <= off_p) ? (eff >= on_p && eff < off_p) : (eff >= on_p || eff < off_p);
		end
	endgenerate
	// warnings leave outputs running; only fatal codes force them off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cam_out <= '0;
		end else if (err_fatal) begin
			cam_out <= '0;
		end else if (out_pending_reg && out_delay_cnt_reg == 32'(CTRL_CYCLES / 2 - 1)) begin
			cam_out <= cam_next;
		end
	end
endmodule

// *** tb/citc_props.sv ***
// checker for the dead-time compensation core
// assumes the shortened control cycle of 10 clocks
module citc_props import citc_pkg::*; #(
	parameter int N_OUT = 16,
	parameter int PW = 16,
	parameter int CW = 12,
	parameter int CTRL_CYCLES = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [PW-1:0] enc_pos,
	input wire logic [1:0] method_sel,
	input wire logic err_valid,
	input wire logic [6:0] err_code,
	input wire logic err_ack,
	input wire logic [N_OUT-1:0] cam_out,
	input wire logic [CW-1:0] deadtime_correction,
	input wire logic [6:0] err_code_out,
	input wire logic err_pending,
	input wire logic err_fatal,
	input wire logic cycle_tick
);
	localparam int LONG = 4 * CTRL_CYCLES;
	localparam int D_LO = CTRL_CYCLES / 2 - 1;
	localparam int D_HI = CTRL_CYCLES / 2 + 2;
	logic [1:0] meth_reg;
	logic [PW-1:0] pos_reg;
	logic [7:0] meth_age, pos_age, tick_age;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meth_reg <= 2'h0;
			pos_reg <= '0;
			meth_age <= 8'h0;
			pos_age <= 8'h0;
			tick_age <= 8'h0;
		end else begin
			meth_reg <= method_sel;
			pos_reg <= enc_pos;
			meth_age <= (method_sel != meth_reg) ? 8'h0 : meth_age + 8'(meth_age != 8'hff);
			pos_age <= (enc_pos != pos_reg) ? 8'h0 : pos_age + 8'(pos_age != 8'hff);
			tick_age <= cycle_tick ? 8'h0 : tick_age + 8'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_quiet;
		!cycle_tick [*8] ##1 !cycle_tick;
	endsequence
	sequence s_warn;
		err_valid && err_code > 7'h13 && err_code < 7'h64 && !err_pending && !err_fatal;
	endsequence
	a_tick_period: assert property (cycle_tick |=> s_quiet ##1 cycle_tick)
		else $error("control cycle length wrong");
	a_corr_on_tick: assert property ($changed(deadtime_correction) |-> $past(cycle_tick))
		else $error("correction moved off a cycle boundary");
	a_step_limit: assert property ($changed(deadtime_correction) && meth_age > LONG && method_sel != 2'h2 |->
		deadtime_correction - $past(deadtime_correction) == 1 || $past(deadtime_correction) - deadtime_correction == 1)
		else $error("correction stepped by more than one");
	a_path_hold: assert property (pos_age > LONG && meth_age > LONG && method_sel inside {2'h0, 2'h3} |->
		$stable(deadtime_correction))
		else $error("correction moved at standstill");
	a_cam_delay: assert property ($changed(cam_out) && !err_fatal && !$past(err_fatal) |->
		tick_age inside {[D_LO:D_HI]})
		else $error("output update at wrong delay");
	a_err_capture: assert property (s_warn |=> err_pending && err_code_out == $past(err_code))
		else $error("error code not presented");
	a_ack_clear: assert property (err_ack && !err_valid && !err_fatal |=> !err_pending)
		else $error("ack did not clear error");
	a_fatal_stop: assert property (err_fatal |=> err_fatal && cam_out == '0)
		else $error("fatal error did not stop outputs");
endmodule
bind citc_top citc_props #(.N_OUT(N_OUT), .PW(PW), .CW(CW), .CTRL_CYCLES(CTRL_CYCLES)) i_props (
	.clk(clk), .rst(rst), .enc_pos(enc_pos), .method_sel(method_sel), .err_valid(err_valid),
	.err_code(err_code), .err_ack(err_ack), .cam_out(cam_out), .deadtime_correction(deadtime_correction),
	.err_code_out(err_code_out), .err_pending(err_pending), .err_fatal(err_fatal), .cycle_tick(cycle_tick));

// *** tb/citc_enc_model.sv ***
// encoder stand-in: one increment every period_clks clocks
// assumes period_clks of zero means standstill
module citc_enc_model #(
	parameter int PW = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] period_clks,
	output logic [PW-1:0] pos
);
	logic [7:0] div_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_reg <= 8'h0;
			pos <= '0;
		end else if (period_clks != 8'h0) begin
			div_reg <= (div_reg + 8'h1 >= period_clks) ? 8'h0 : div_reg + 8'h1;
			if (div_reg + 8'h1 >= period_clks)
				pos <= pos + 1'b1;
		end
	end
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the dead-time compensation core
// assumes 40 clocks per ms and 10 clocks per control cycle
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] speed = 8'h0;
	logic [1:0] method_sel = 2'h0;
	logic [9:0] deadtime_ms = 10'h0;
	logic [15:0] comp_enable = 16'h0001;
	logic [255:0] cam_on = '0, cam_off = '0;
	logic err_valid = 1'b0, err_ack = 1'b0;
	logic [6:0] err_code = 7'h0, code_out;
	logic [15:0] enc_pos, cam_out, p;
	logic [11:0] corr, req, c0;
	logic [4:0] period;
	logic pend, fatal, led, tick;
	int bad_count = 0, tests_run = 0, cycles = 0;
	always #12.5 clk = ~clk;
	citc_enc_model #(.PW(16)) i_enc (.clk(clk), .rst(rst), .period_clks(speed), .pos(enc_pos));
	citc_top #(.SAMPLE_CYCLES(40), .CTRL_CYCLES(10)) i_dut (.clk(clk), .rst(rst), .enc_pos(enc_pos),
		.method_sel(method_sel), .deadtime_ms(deadtime_ms), .comp_enable(comp_enable), .cam_on(cam_on),
		.cam_off(cam_off), .err_valid(err_valid), .err_code(err_code), .err_ack(err_ack), .cam_out(cam_out),
		.deadtime_correction(corr), .required_correction(req), .recalc_period_ms(period),
		.err_code_out(code_out), .err_pending(pend), .err_fatal(fatal), .diag_led(led), .cycle_tick(tick));
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic chkb(input string what, input logic ok);
		chk(what, 16'h1, {15'h0, ok});
	endtask
	task automatic window(input int k, input logic [15:0] on, input logic [15:0] off);
		cam_on[k*16 +: 16] = on;
		cam_off[k*16 +: 16] = off;
	endtask
	task automatic raise(input logic [6:0] code);
		err_code = code;
		err_valid = 1'b1;
		step(1);
		err_valid = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_period();
		chk("cam_out", 16'h0, cam_out);
		comp_enable = 16'h0a00;
		step(1);
		chk("period", 16'd12, {11'h0, period});
		comp_enable = 16'h0001;
		step(1);
		chk("period", 16'd1, {11'h0, period});
	endtask
	task automatic t_direct();
		method_sel = 2'h2;
		deadtime_ms = 10'd5;
		speed = 8'd4;
		step(300);
		chk("required", 16'd50, {4'h0, req});
		deadtime_ms = 10'd999;
		step(200);
		chk("applied", 16'hfff, {4'h0, corr});
		deadtime_ms = 10'd5;
		step(200);
		chk("applied", 16'd50, {4'h0, corr});
	endtask
	task automatic t_path();
		method_sel = 2'h3;
		step(30);
		speed = 8'h0;
		p = enc_pos;
		window(0, p - 16'd10, p + 16'd20);
		window(1, p - 16'd10, p + 16'd20);
		step(300);
		chk("required", 16'h0, {4'h0, req});
		chk("applied", 16'd50, {4'h0, corr});
		chk("cam pair", 16'h2, {14'h0, cam_out[1:0]});
		speed = 8'd20;
		step(200);
		chkb("path step", corr >= 12'd40 && corr < 12'd50);
		speed = 8'h0;
		step(60);
		c0 = corr;
		method_sel = 2'h1;
		step(100);
		chkb("timed step", c0 - corr >= 12'd8 && c0 - corr <= 12'd11);
		step(600);
		chk("applied", 16'h0, {4'h0, corr});
	endtask
	task automatic t_errors();
		p = enc_pos;
		window(1, p - 16'd5, p + 16'd5);
		step(30);
		raise(7'd25);
		chk("code", 16'd25, {9'h0, code_out});
		window(1, p + 16'd5, p + 16'd9);
		step(30);
		chk("out1", 16'h0, {15'h0, cam_out[1]});
		raise(7'd0);
		chkb("pending", pend && code_out === 7'd25);
		err_ack = 1'b1;
		step(1);
		err_ack = 1'b0;
		chkb("cleared", !pend);
		chk("diag_led", 16'h0, {15'h0, led});
		window(1, p - 16'd5, p + 16'd5);
		step(30);
		raise(7'd7);
		err_ack = 1'b1;
		step(1);
		err_ack = 1'b0;
		step(2);
		chkb("fatal", fatal && cam_out === 16'h0);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 6000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	initial begin
		step(12);
		rst = 1'b0;
		step(1);
		t_period();
		t_direct();
		t_path();
		t_errors();
		tally_and_finish();
	end
endmodule
